// ---- bzc_regs.svh ----
`ifndef BZC_REGS_SVH
`define BZC_REGS_SVH
`define BZC_ADDR_W 8
`define BZC_DATA_W 8
`define BZC_CODE_W 7
`define BZC_OFS_INDOOR_MAX 8'h10
`define BZC_OFS_INDOOR_DIM 8'h11
`define BZC_OFS_DARK_MAX 8'h12
`define BZC_OFS_DARK_DIM 8'h13
`define BZC_CODE_RESET 7'h00
`define BZC_CODE_ZERO 7'h00
`define BZC_CODE_FULL_SCALE 7'h7f
`define BZC_RSVD_READ 1'b0
`define BZC_RDATA_IDLE 8'h00
`define BZC_ZONE_W 3
`define BZC_ZONE_INDOOR 3'h4
`define BZC_ZONE_DARK 3'h5
`define BZC_READ_BACK_LAG 2
`endif

// ---- bzc_pkg.sv ----
`default_nettype none
package bzc_pkg;
  typedef enum logic {BZC_FULL, BZC_DIMMED} bzc_level_t;
endpackage : bzc_pkg
`default_nettype wire

// ---- bzc_code_reg.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bzc_regs.svh"
module bzc_code_reg
  import bzc_pkg::*;
#(
  parameter logic [7:0] OFFSET = `BZC_OFS_INDOOR_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`BZC_ADDR_W-1:0] addr_i,
  input wire logic [`BZC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  output logic hit_o,
  output logic [`BZC_CODE_W-1:0] code_o
);
  logic [`BZC_CODE_W-1:0] code_reg;
  logic [`BZC_CODE_W-1:0] code_next;

  assign hit_o = (addr_i == OFFSET);
  // Bit 7 is never stored, so it cannot leak back on a read
  assign code_next = (wr_i && hit_o) ? wdata_i[`BZC_CODE_W-1:0] : code_reg;
  assign code_o = code_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_reg <= `BZC_CODE_RESET;
    end else begin
      code_reg <= code_next;
    end
  end
endmodule : bzc_code_reg
`default_nettype wire

// ---- bzc_zone_current.sv ----
// Operation
// - Register 0x10 holds indoor full code, bit7 reserved
// - Register 0x11 holds indoor dimmed code, bit7 reserved
// - Register 0x12 holds dark full code, bit7 reserved
// - Register 0x13 holds dark dimmed code, bit7 reserved
// - Dim on timeout or dim-enable flag
// - Seven-bit code maps nonlinearly, 0 to 30 mA
`timescale 1ns/10ps
`default_nettype none
`include "bzc_regs.svh"
module bzc_zone_current
  import bzc_pkg::*;
#(
  parameter int CODE_W = `BZC_CODE_W
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic [`BZC_ADDR_W-1:0] REG_ADDR_I,
  input wire logic [`BZC_DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [`BZC_ZONE_W-1:0] ZONE_I,
  input wire logic DIM_TIMEOUT_I,
  input wire logic DIM_EN_I,
  output logic [`BZC_DATA_W-1:0] REG_RDATA_O,
  output logic REG_HIT_O,
  output logic [`BZC_CODE_W-1:0] BL_CODE_O,
  output logic BL_ACTIVE_O,
  output logic BL_DIMMED_O,
  output logic BL_ZERO_O
);
  if (CODE_W != `BZC_CODE_W) begin : g_code_w_check
    $error("CODE_W must equal the DAC code width");
  end

  logic [`BZC_CODE_W-1:0] indoor_full_code;
  logic [`BZC_CODE_W-1:0] indoor_dimmed_code;
  logic [`BZC_CODE_W-1:0] dark_full_code;
  logic [`BZC_CODE_W-1:0] dark_dimmed_code;
  logic hit_indoor_max;
  logic hit_indoor_dim;
  logic hit_dark_max;
  logic hit_dark_dim;

  bzc_code_reg #(.OFFSET(`BZC_OFS_INDOOR_MAX)) u_indoor_max_current (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I),
    .wr_i(REG_WR_I),
    .hit_o(hit_indoor_max),
    .code_o(indoor_full_code)
  );

  bzc_code_reg #(.OFFSET(`BZC_OFS_INDOOR_DIM)) u_indoor_dim_current (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I),
    .wr_i(REG_WR_I),
    .hit_o(hit_indoor_dim),
    .code_o(indoor_dimmed_code)
  );

  bzc_code_reg #(.OFFSET(`BZC_OFS_DARK_MAX)) u_dark_max_current (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I),
    .wr_i(REG_WR_I),
    .hit_o(hit_dark_max),
    .code_o(dark_full_code)
  );

  bzc_code_reg #(.OFFSET(`BZC_OFS_DARK_DIM)) u_dark_dim_current (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I),
    .wr_i(REG_WR_I),
    .hit_o(hit_dark_dim),
    .code_o(dark_dimmed_code)
  );

  // Read decode; unmapped offsets read zero
  wire any_hit = hit_indoor_max | hit_indoor_dim | hit_dark_max | hit_dark_dim;
  wire [`BZC_CODE_W-1:0] read_code =
    hit_indoor_max ? indoor_full_code :
    hit_indoor_dim ? indoor_dimmed_code :
    hit_dark_max ? dark_full_code :
    hit_dark_dim ? dark_dimmed_code : `BZC_CODE_ZERO;
  wire [`BZC_DATA_W-1:0] rdata_next = REG_RD_I ? {`BZC_RSVD_READ, read_code} : REG_RDATA_O;

  function automatic logic zone_is(input logic [`BZC_ZONE_W-1:0] zone, input logic [`BZC_ZONE_W-1:0] level);
    return zone == level;
  endfunction : zone_is

  // Zone and level selection
  wire zone_indoor = zone_is(ZONE_I, `BZC_ZONE_INDOOR);
  wire zone_dark = zone_is(ZONE_I, `BZC_ZONE_DARK);
  wire zone_ours = zone_indoor | zone_dark;
  bzc_level_t level_next;
  assign level_next = (DIM_TIMEOUT_I || DIM_EN_I) ? BZC_DIMMED : BZC_FULL;
  wire [`BZC_CODE_W-1:0] full_code = zone_dark ? dark_full_code : indoor_full_code;
  wire [`BZC_CODE_W-1:0] dimmed_code = zone_dark ? dark_dimmed_code : indoor_dimmed_code;
  // Code goes to the DAC unchanged; the current curve lives in the analog side
  wire [`BZC_CODE_W-1:0] code_next = !zone_ours ? `BZC_CODE_ZERO :
    (level_next == BZC_DIMMED) ? dimmed_code : full_code;

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= `BZC_RDATA_IDLE;
      REG_HIT_O <= 1'b0;
    end else begin
      REG_RDATA_O <= rdata_next;
      REG_HIT_O <= (REG_RD_I || REG_WR_I) && any_hit;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BL_CODE_O <= `BZC_CODE_ZERO;
      BL_ACTIVE_O <= 1'b0;
      BL_DIMMED_O <= 1'b0;
      BL_ZERO_O <= 1'b1;
    end else begin
      BL_CODE_O <= code_next;
      BL_ACTIVE_O <= zone_ours;
      BL_DIMMED_O <= zone_ours && (level_next == BZC_DIMMED);
      BL_ZERO_O <= (code_next == `BZC_CODE_ZERO);
    end
  end

  // Checks
  sequence s_write_indoor_max;
    REG_WR_I && REG_ADDR_I == `BZC_OFS_INDOOR_MAX;
  endsequence
  sequence s_write_dark_max;
    REG_WR_I && hit_dark_max;
  endsequence
  sequence s_read_dark_max;
    REG_RD_I && hit_dark_max && !REG_WR_I;
  endsequence
  sequence s_access_mapped;
    (REG_RD_I || REG_WR_I) && any_hit;
  endsequence

  // Stored codes
  a_indoor_max_store: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    s_write_indoor_max |=> indoor_full_code == $past(REG_WDATA_I[`BZC_CODE_W-1:0]))
    else $error("indoor full code not stored");
  a_indoor_dim_store: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_WR_I && REG_ADDR_I == `BZC_OFS_INDOOR_DIM |=> indoor_dimmed_code == $past(REG_WDATA_I[`BZC_CODE_W-1:0]))
    else $error("indoor dimmed code not stored");
  a_dark_max_store: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_WR_I && REG_ADDR_I == `BZC_OFS_DARK_MAX |=> dark_full_code == $past(REG_WDATA_I[`BZC_CODE_W-1:0]))
    else $error("dark full code not stored");
  a_dark_dim_store: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_WR_I && REG_ADDR_I == `BZC_OFS_DARK_DIM |=> dark_dimmed_code == $past(REG_WDATA_I[`BZC_CODE_W-1:0]))
    else $error("dark dimmed code not stored");
  a_indoor_max_keeps: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_WR_I || !hit_indoor_max |=> $stable(indoor_full_code))
    else $error("indoor full code changed without a write");
  a_indoor_dim_keeps: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_WR_I || !hit_indoor_dim |=> $stable(indoor_dimmed_code))
    else $error("indoor dimmed code changed without a write");
  a_dark_max_keeps: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_WR_I || !hit_dark_max |=> $stable(dark_full_code))
    else $error("dark full code changed without a write");
  a_dark_dim_keeps: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_WR_I || !hit_dark_dim |=> $stable(dark_dimmed_code))
    else $error("dark dimmed code changed without a write");

  // Read port
  a_read_indoor_max: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_RD_I && hit_indoor_max |=> REG_RDATA_O == {`BZC_RSVD_READ, $past(indoor_full_code)})
    else $error("indoor full code read back wrong");
  a_read_indoor_dim: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_RD_I && hit_indoor_dim |=> REG_RDATA_O == {`BZC_RSVD_READ, $past(indoor_dimmed_code)})
    else $error("indoor dimmed code read back wrong");
  a_read_dark_max: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_RD_I && hit_dark_max |=> REG_RDATA_O == {`BZC_RSVD_READ, $past(dark_full_code)})
    else $error("dark full code read back wrong");
  a_read_dark_dim: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_RD_I && hit_dark_dim |=> REG_RDATA_O == {`BZC_RSVD_READ, $past(dark_dimmed_code)})
    else $error("dark dimmed code read back wrong");
  a_unmapped_read_zero: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    REG_RD_I && !any_hit |=> REG_RDATA_O == `BZC_RDATA_IDLE)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data changed without a read");
  a_hit_on_access: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    s_access_mapped |=> REG_HIT_O)
    else $error("hit flag missing after mapped access");
  a_hit_idle_low: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_RD_I && !REG_WR_I |=> !REG_HIT_O)
    else $error("hit flag set without an access");
  a_read_back_rsvd: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    s_write_dark_max ##1 s_read_dark_max
      |=> REG_RDATA_O == {`BZC_RSVD_READ, $past(REG_WDATA_I[`BZC_CODE_W-1:0], `BZC_READ_BACK_LAG)})
    else $error("read back mismatch or reserved bit set");

  // Backlight output
  a_dim_select_code: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    zone_dark && DIM_EN_I |=> BL_DIMMED_O && BL_CODE_O == $past(dark_dimmed_code))
    else $error("dim request did not select dimmed code");
  a_timeout_dims: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    zone_indoor && DIM_TIMEOUT_I |=> BL_DIMMED_O && BL_CODE_O == $past(indoor_dimmed_code))
    else $error("dim timeout did not select dimmed code");
  a_dim_level_flag: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    zone_ours && (DIM_TIMEOUT_I || DIM_EN_I) |=> BL_ACTIVE_O && BL_DIMMED_O)
    else $error("dimmed flag missing");
  a_indoor_full_awake: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    zone_indoor && !DIM_TIMEOUT_I && !DIM_EN_I |=> BL_ACTIVE_O && !BL_DIMMED_O && BL_CODE_O == $past(indoor_full_code))
    else $error("indoor full code not selected");
  a_dark_full_awake: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    zone_dark && !DIM_TIMEOUT_I && !DIM_EN_I |=> BL_ACTIVE_O && !BL_DIMMED_O && BL_CODE_O == $past(dark_full_code))
    else $error("dark full code not selected");
  a_foreign_zone_zero: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !zone_ours |=> !BL_ACTIVE_O && !BL_DIMMED_O && BL_CODE_O == `BZC_CODE_ZERO)
    else $error("foreign zone drove a code");
  a_zero_code_flag: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    BL_ZERO_O == (BL_CODE_O == `BZC_CODE_ZERO))
    else $error("zero flag disagrees with code");
endmodule : bzc_zone_current
`default_nettype wire

// ---- bzc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module bzc_host_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One byte per call; idle bus shows inverted values so stale data never passes
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
  endtask : put
  // Write, then read the same offset on the very next edge
  task automatic put_pair(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} = {a, d, 2'b10};
    @(negedge clk_i);
    {wr_o, rd_o} = 2'b01;
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
  endtask : put_pair
endmodule : bzc_host_model
`default_nettype wire

// ---- bzc_zone_current_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module bzc_zone_current_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] zone = 3'h0;
  logic tmo = 1'b0;
  logic den = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, hit, act, dim, zero;
  logic [6:0] code;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  bzc_host_model bzc_host_model_i (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  bzc_zone_current bzc_zone_current_i (.CORE_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .ZONE_I(zone), .DIM_TIMEOUT_I(tmo), .DIM_EN_I(den), .REG_RDATA_O(rdata),
    .REG_HIT_O(hit), .BL_CODE_O(code), .BL_ACTIVE_O(act), .BL_DIMMED_O(dim), .BL_ZERO_O(zero));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic reset_values;
    for (int i = 0; i < 4; i++) begin
      bzc_host_model_i.put(8'h10 + 8'(i), 8'h00, 1'b0);
      chk(rdata, 8'h00);
    end
    chk({7'h00, zero}, 8'h01);
  endtask : reset_values
  task automatic write_read;
    for (int i = 0; i < 4; i++) begin
      bzc_host_model_i.put(8'h10 + 8'(i), 8'hfc + 8'(i), 1'b1);
      bzc_host_model_i.put(8'h10 + 8'(i), 8'h00, 1'b0);
      chk(rdata, 8'h7c + 8'(i));
      chk({7'h00, hit}, 8'h01);
    end
  endtask : write_read
  task automatic unmapped;
    bzc_host_model_i.put(8'h14, 8'h55, 1'b1);
    bzc_host_model_i.put(8'h14, 8'h00, 1'b0);
    chk({hit, rdata[6:0]}, 8'h00);
    bzc_host_model_i.put(8'h0f, 8'h00, 1'b1);
    bzc_host_model_i.put(8'h10, 8'h00, 1'b0);
    chk(rdata, 8'h7c);
  endtask : unmapped
  task automatic back_to_back;
    bzc_host_model_i.put_pair(8'h12, 8'h81);
    chk(rdata, 8'h01);
    chk({7'h00, hit}, 8'h01);
    bzc_host_model_i.put_pair(8'h12, 8'hfe);
    chk(rdata, 8'h7e);
  endtask : back_to_back
  // Reset in mid-run must clear the stored codes too
  task automatic mid_reset;
    @(negedge clk);
    zone = 3'h5;
    rst = 1'b1;
    @(negedge clk);
    chk({1'b0, code}, 8'h00);
    chk({5'h00, act, dim, zero}, 8'h01);
    rst = 1'b0;
    bzc_host_model_i.put(8'h13, 8'h00, 1'b0);
    chk(rdata, 8'h00);
    chk({5'h00, act, dim, zero}, 8'h05);
  endtask : mid_reset
  // Last pass leaves our zones: code must fall to zero
  task automatic backlight;
    for (int k = 0; k < 9; k++) begin
      @(negedge clk);
      zone = (k == 8) ? 3'h3 : (k[2] ? 3'h5 : 3'h4);
      tmo = k[1];
      den = k[0];
      @(negedge clk);
      chk({1'b0, code}, (k == 8) ? 8'h00 : 8'h7c + 8'({k[2], k[1] | k[0]}));
      chk({5'h00, act, dim, zero}, (k == 8) ? 8'h01 : {6'h01, k[1] | k[0], 1'b0});
    end
  endtask : backlight
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    reset_values();
    write_read();
    unmapped();
    back_to_back();
    backlight();
    mid_reset();
    tally_and_finish();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule : bzc_zone_current_tb_top
`default_nettype wire
